// [common/asdc_consts.vh]
// Constants for the accelerometer sample duty cycler
`ifndef ASDC_CONSTS_VH
`define ASDC_CONSTS_VH
`define ASDC_CHAN_X          3'h1
`define ASDC_CHAN_Y          3'h2
`define ASDC_CHAN_Z          3'h0
`define ASDC_PIN_ENABLE      8'h07
`define ASDC_CONV_CONFIG     8'h60
`define ASDC_CLK_HZ          25000000
`define ASDC_PERIOD_MS       50
`define ASDC_PERIOD_CYC      ((`ASDC_CLK_HZ / 1000) * `ASDC_PERIOD_MS)
`define ASDC_ACK_EVERY       8
`define ASDC_EXP_RST         3'h0
`define ASDC_RANGE_RST       2'h0
`endif

// [rtl/asdc_fifo.v]
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module asdc_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output reg  [WIDTH-1:0] out_data_o,
  output reg              out_valid_o,
  input  wire             out_ready_i
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW:0]      wr_reg;
  reg [AW:0]      rd_reg;
  wire            full;
  wire            empty;
  wire            do_wr;
  wire            do_rd;
  assign full       = (wr_reg[AW-1:0] == rd_reg[AW-1:0]) && (wr_reg[AW] != rd_reg[AW]);
  assign empty      = (wr_reg == rd_reg);
  assign in_ready_o = ~full;
  assign do_wr      = in_valid_i & ~full;
  assign do_rd      = ~empty & (~out_valid_o | out_ready_i);
  // Storage write
  always @(posedge clk_i) begin
    if (do_wr) begin
      mem_reg[wr_reg[AW-1:0]] <= in_data_i;
    end
  end
  // Pointers and registered output stage
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_reg      <= {(AW+1){1'b0}};
      rd_reg      <= {(AW+1){1'b0}};
      out_valid_o <= 1'b0;
      out_data_o  <= {WIDTH{1'b0}};
    end else begin
      if (do_wr) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (do_rd) begin
        out_data_o  <= mem_reg[rd_reg[AW-1:0]];
        out_valid_o <= 1'b1;
        rd_reg      <= rd_reg + 1'b1;
      end else if (out_ready_i) begin
        out_valid_o <= 1'b0;
      end
    end
  end
endmodule // asdc_fifo

// [rtl/asdc_sequencer.v]
// Acquisition and duty-cycle sequencer for a three-axis accelerometer node
`timescale 1ns/1ns
`include "asdc_consts.vh"
module asdc_sequencer #(
  parameter PERIOD_CYC = `ASDC_PERIOD_CYC,
  parameter FIFO_DEPTH = 16
) (
  input  wire        clk_i,
  input  wire        rst_i,
  // Software controls
  input  wire [2:0]  average_exponent_i,
  input  wire [1:0]  range_sel_cfg_i,
  input  wire        run_i,
  // Converter
  output reg  [7:0]  analog_pin_enable_o,
  output reg  [7:0]  converter_config_o,
  output reg  [2:0]  converter_channel_select_o,
  output reg         conv_start_o,
  input  wire        conversion_complete_flag_i,
  input  wire [7:0]  conversion_result_i,
  // Radio
  output reg  [23:0] tx_data_o,
  output reg         tx_valid_o,
  input  wire        tx_ready_i,
  input  wire        tx_done_i,
  output reg         rx_window_o,
  input  wire        rx_done_i,
  output reg  [31:0] radio_compare_o,
  output reg         radio_compare_load_o,
  output reg         radio_doze_o,
  input  wire        radio_irq_n_i,
  output reg         stopped_o,
  // Sensor range
  output reg         range_select_0_o,
  output reg         range_select_1_o
);
  // One-hot states
  localparam S_INIT  = 9'h001;
  localparam S_START = 9'h002;
  localparam S_WAIT  = 9'h004;
  localparam S_PUSH  = 9'h008;
  localparam S_TX    = 9'h010;
  localparam S_RX    = 9'h020;
  localparam S_ARM   = 9'h040;
  localparam S_STOP  = 9'h080;
  localparam S_IDLE  = 9'h100;

  reg  [8:0]  state_reg;
  reg  [8:0]  state_next;
  reg  [1:0]  axis_reg;
  reg  [1:0]  axis_next;
  reg  [7:0]  iter_reg;
  reg  [7:0]  iter_next;
  reg  [14:0] acc_x_reg;
  reg  [14:0] acc_x_next;
  reg  [14:0] acc_y_reg;
  reg  [14:0] acc_y_next;
  reg  [14:0] acc_z_reg;
  reg  [14:0] acc_z_next;
  reg  [2:0]  exp_reg;
  reg  [2:0]  exp_next;
  reg  [2:0]  loop_reg;
  reg  [2:0]  loop_next;
  reg  [31:0] elapsed_reg;
  reg  [31:0] elapsed_next;
  reg         irq_s1_reg;
  reg         irq_s2_reg;
  reg         conversion_complete_flag_s1_reg;
  reg         conversion_complete_flag_s2_reg;
  reg  [7:0]  res_s1_reg;
  reg  [7:0]  res_s2_reg;
  reg         fifo_valid;
  reg  [23:0] fifo_data;
  wire        fifo_ready;
  wire [23:0] fifo_out_data;
  wire        fifo_out_valid;
  wire [7:0]  iter_total;
  wire [14:0] sh_x;
  wire [14:0] sh_y;
  wire [14:0] sh_z;
  wire [7:0]  val_x;
  wire [7:0]  val_y;
  wire [7:0]  val_z;
  wire [31:0] period_cyc;
  wire        tx_load;

  assign period_cyc = PERIOD_CYC;
  // Samples per axis is 2^N
  assign iter_total = 8'h01 << exp_reg;
  // Scale back to 8 bits, then fix orientation
  assign sh_x  = acc_x_reg >> exp_reg;
  assign sh_y  = acc_y_reg >> exp_reg;
  assign sh_z  = acc_z_reg >> exp_reg;
  assign val_x = ~sh_x[7:0];
  assign val_y = ~sh_y[7:0];
  assign val_z = sh_z[7:0];

  // Synchronisers for pins from the outside world
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_s1_reg  <= 1'b1;
      irq_s2_reg  <= 1'b1;
      conversion_complete_flag_s1_reg <= 1'b0;
      conversion_complete_flag_s2_reg <= 1'b0;
      res_s1_reg  <= 8'h00;
      res_s2_reg  <= 8'h00;
    end else begin
      irq_s1_reg  <= radio_irq_n_i;
      irq_s2_reg  <= irq_s1_reg;
      conversion_complete_flag_s1_reg <= conversion_complete_flag_i;
      conversion_complete_flag_s2_reg <= conversion_complete_flag_s1_reg;
      res_s1_reg  <= conversion_result_i;
      res_s2_reg  <= res_s1_reg;
    end
  end

  // Next-state logic
  always @* begin
    state_next   = state_reg;
    axis_next    = axis_reg;
    iter_next    = iter_reg;
    acc_x_next   = acc_x_reg;
    acc_y_next   = acc_y_reg;
    acc_z_next   = acc_z_reg;
    exp_next     = exp_reg;
    loop_next    = loop_reg;
    elapsed_next = elapsed_reg + 32'h1;
    fifo_valid   = 1'b0;
    fifo_data    = {val_x, val_y, val_z};
    case (state_reg)
      S_INIT: begin
        // Pins and converter set up before anything converts
        state_next = S_IDLE;
      end
      S_IDLE: begin
        if (run_i) begin
          state_next   = S_START;
          elapsed_next = 32'h0;
          exp_next     = average_exponent_i;
          acc_x_next   = 15'h0;
          acc_y_next   = 15'h0;
          acc_z_next   = 15'h0;
          axis_next    = 2'h0;
          iter_next    = 8'h0;
        end
      end
      S_START: begin
        state_next = S_WAIT;
      end
      S_WAIT: begin
        // Accumulate once the complete flag is seen
        if (conversion_complete_flag_s2_reg) begin
          case (axis_reg)
            2'h0:    acc_x_next = acc_x_reg + {7'h0, res_s2_reg};
            2'h1:    acc_y_next = acc_y_reg + {7'h0, res_s2_reg};
            default: acc_z_next = acc_z_reg + {7'h0, res_s2_reg};
          endcase
          if (axis_reg == 2'h2) begin
            axis_next = 2'h0;
            iter_next = iter_reg + 8'h1;
            if (iter_reg + 8'h1 == iter_total) begin
              state_next = S_PUSH;
            end else begin
              state_next = S_START;
            end
          end else begin
            axis_next  = axis_reg + 2'h1;
            state_next = S_START;
          end
        end
      end
      S_PUSH: begin
        // All axes acquired: queue the sample
        fifo_valid = 1'b1;
        if (fifo_ready) begin
          state_next = S_TX;
        end
      end
      S_TX: begin
        if (tx_done_i) begin
          if (loop_reg == 3'h7) begin
            state_next = S_RX;
          end else begin
            state_next = S_ARM;
          end
          loop_next = loop_reg + 3'h1;
        end
      end
      S_RX: begin
        if (rx_done_i) begin
          state_next = S_ARM;
        end
      end
      S_ARM: begin
        state_next = S_STOP;
      end
      S_STOP: begin
        // Radio compare interrupt ends the stop
        if (!irq_s2_reg) begin
          state_next = S_IDLE;
        end
      end
      default: begin
        state_next = S_INIT;
      end
    endcase
  end

  // State registers
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg   <= S_INIT;
      axis_reg    <= 2'h0;
      iter_reg    <= 8'h0;
      acc_x_reg   <= 15'h0;
      acc_y_reg   <= 15'h0;
      acc_z_reg   <= 15'h0;
      exp_reg     <= `ASDC_EXP_RST;
      loop_reg    <= 3'h0;
      elapsed_reg <= 32'h0;
    end else begin
      state_reg   <= state_next;
      axis_reg    <= axis_next;
      iter_reg    <= iter_next;
      acc_x_reg   <= acc_x_next;
      acc_y_reg   <= acc_y_next;
      acc_z_reg   <= acc_z_next;
      exp_reg     <= exp_next;
      loop_reg    <= loop_next;
      elapsed_reg <= elapsed_next;
    end
  end

  // Registered outputs
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      analog_pin_enable_o        <= 8'h00;
      converter_config_o         <= 8'h00;
      converter_channel_select_o <= `ASDC_CHAN_X;
      conv_start_o               <= 1'b0;
      rx_window_o                <= 1'b0;
      radio_compare_o            <= 32'h0;
      radio_compare_load_o       <= 1'b0;
      radio_doze_o               <= 1'b0;
      stopped_o                  <= 1'b0;
      range_select_0_o           <= 1'b0;
      range_select_1_o           <= 1'b0;
    end else begin
      conv_start_o         <= 1'b0;
      radio_compare_load_o <= 1'b0;
      range_select_0_o     <= range_sel_cfg_i[0];
      range_select_1_o     <= range_sel_cfg_i[1];
      if (state_reg == S_INIT) begin
        analog_pin_enable_o <= `ASDC_PIN_ENABLE;
        converter_config_o  <= `ASDC_CONV_CONFIG;
      end
      if (state_reg == S_START) begin
        conv_start_o <= 1'b1;
        case (axis_reg)
          2'h0:    converter_channel_select_o <= `ASDC_CHAN_X;
          2'h1:    converter_channel_select_o <= `ASDC_CHAN_Y;
          default: converter_channel_select_o <= `ASDC_CHAN_Z;
        endcase
      end
      rx_window_o <= (state_next == S_RX);
      if (state_reg == S_ARM) begin
        // Remaining time of the 50 ms frame, at least one cycle
        if (elapsed_reg + 32'h1 < period_cyc) begin
          radio_compare_o <= period_cyc - elapsed_reg - 32'h1;
        end else begin
          radio_compare_o <= 32'h1;
        end
        radio_compare_load_o <= 1'b1;
      end
      radio_doze_o <= (state_next == S_STOP);
      stopped_o    <= (state_next == S_STOP);
    end
  end

  // Output stage reloads when empty or when the radio takes its word
  assign tx_load = ~tx_valid_o | tx_ready_i;

  // Output FIFO feeding the radio
  asdc_fifo #(
    .WIDTH (24),
    .DEPTH (FIFO_DEPTH),
    .AW    (4)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_data_i   (fifo_data),
    .in_valid_i  (fifo_valid),
    .in_ready_o  (fifo_ready),
    .out_data_o  (fifo_out_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (tx_load)
  );

  // Radio-facing copy of the FIFO head
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_data_o  <= 24'h0;
      tx_valid_o <= 1'b0;
    end else begin
      if (tx_load) begin
        tx_data_o  <= fifo_out_data;
        tx_valid_o <= fifo_out_valid;
      end
    end
  end
endmodule // asdc_sequencer

// [verif/asdc_sequencer_properties.sv]
// Port checks for the sequencer
`timescale 1ns/1ns
`include "asdc_consts.vh"
module asdc_sequencer_checker #(parameter PERIOD_CYC = 2000) (
  input wire        clk_i,
  input wire        rst_i,
  input wire [1:0]  range_sel_cfg_i,
  input wire [7:0]  analog_pin_enable_o,
  input wire [7:0]  converter_config_o,
  input wire [2:0]  converter_channel_select_o,
  input wire        conv_start_o,
  input wire        conversion_complete_flag_i,
  input wire        tx_valid_o,
  input wire        tx_ready_i,
  input wire        rx_window_o,
  input wire [31:0] radio_compare_o,
  input wire        radio_compare_load_o,
  input wire        radio_doze_o,
  input wire        radio_irq_n_i,
  input wire        stopped_o,
  input wire        range_select_0_o,
  input wire        range_select_1_o
);
  logic [2:0] nxt_ch;
  logic       pend;
  logic [2:0] loops;
  // Expected next channel, open conversion, finished loops
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      nxt_ch <= `ASDC_CHAN_X;
      pend   <= 1'b0;
      loops  <= 3'h0;
    end else begin
      if (conv_start_o)
        nxt_ch <= (converter_channel_select_o == `ASDC_CHAN_X) ? `ASDC_CHAN_Y :
                  (converter_channel_select_o == `ASDC_CHAN_Y) ? `ASDC_CHAN_Z : `ASDC_CHAN_X;
      if (conv_start_o)
        pend <= 1'b1;
      else if (conversion_complete_flag_i)
        pend <= 1'b0;
      if (radio_compare_load_o)
        loops <= loops + 3'h1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_pins_analog: assert property (conv_start_o |-> analog_pin_enable_o == `ASDC_PIN_ENABLE)
    else $error("pins not analog");
  a_conv_config: assert property (conv_start_o |-> converter_config_o == `ASDC_CONV_CONFIG)
    else $error("bad converter setup");
  a_axis_order: assert property (conv_start_o |-> converter_channel_select_o == nxt_ch)
    else $error("bad channel order");
  a_start_after_flag: assert property (conv_start_o |-> !pend)
    else $error("start before complete");
  a_tx_after_axes: assert property ($rose(tx_valid_o) |-> nxt_ch == `ASDC_CHAN_X && !pend)
    else $error("send before axes done");
  a_compare_range: assert property (radio_compare_load_o |-> radio_compare_o >= 1 && radio_compare_o < PERIOD_CYC)
    else $error("sleep length out of range");
  a_doze_follows: assert property (radio_compare_load_o |-> ##[1:4] (radio_doze_o && stopped_o))
    else $error("no stop after load");
  a_stop_hold: assert property ((stopped_o && radio_irq_n_i) [*3] |=> stopped_o)
    else $error("woke without irq");
  a_wake_irq: assert property (stopped_o && !radio_irq_n_i |-> ##[1:4] !stopped_o)
    else $error("irq did not wake");
  a_rx_eighth: assert property ($rose(rx_window_o) |-> loops == 3'h7)
    else $error("ack window on wrong loop");
  a_range_copy: assert property ({range_select_1_o, range_select_0_o} == $past(range_sel_cfg_i))
    else $error("range select not followed");
  c_ack: cover property ($rose(rx_window_o));
  c_send: cover property (tx_valid_o && tx_ready_i);
  c_eighth: cover property (radio_compare_load_o && loops == 3'h7);
endmodule // asdc_sequencer_checker
bind asdc_sequencer asdc_sequencer_checker #(.PERIOD_CYC(PERIOD_CYC)) chk (
  .clk_i, .rst_i, .range_sel_cfg_i, .analog_pin_enable_o, .converter_config_o,
  .converter_channel_select_o, .conv_start_o, .conversion_complete_flag_i, .tx_valid_o,
  .tx_ready_i, .rx_window_o, .radio_compare_o, .radio_compare_load_o, .radio_doze_o,
  .radio_irq_n_i, .stopped_o, .range_select_0_o, .range_select_1_o
);

// [verif/asdc_partner.sv]
// Converter and radio model facing the sequencer
`timescale 1ns/1ns
module asdc_partner (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [7:0]  vx_i,
  input  wire [7:0]  vy_i,
  input  wire [7:0]  vz_i,
  input  wire        start_i,
  input  wire [2:0]  chan_i,
  output logic       flag_o = 1'b0,
  output logic [7:0] res_o = 8'h00,
  input  wire        txv_i,
  output logic       rdy_o = 1'b0,
  output logic       txd_o = 1'b0,
  input  wire        rxw_i,
  output logic       rxd_o = 1'b0,
  input  wire [31:0] cmp_i,
  input  wire        load_i,
  input  wire        doze_i,
  output logic       irq_n_o = 1'b1
);
  int          cw, tw, rw;
  logic [2:0]  ch;
  logic [31:0] tmr;
  logic        r;
  // Far side changes its lines on the falling edge
  always @(negedge clk_i) begin
    r = 1'($urandom_range(0, 1));
    rdy_o <= r;
    // Conversion of 1 to 5 cycles; result stale until it ends
    flag_o <= !start_i && (cw == 1);
    if (start_i) begin
      ch <= chan_i;
      cw <= $urandom_range(1, 5);
      res_o <= ~res_o;
    end else if (cw == 1) begin
      res_o <= (ch == 3'h1) ? vx_i : (ch == 3'h2) ? vy_i : vz_i;
    end
    if (!start_i && cw > 0) cw <= cw - 1;
    // Word taken at the next rising edge; done follows
    if (txv_i && r) tw <= $urandom_range(2, 6);
    else if (tw > 0) tw <= tw - 1;
    txd_o <= (tw == 1) && !(txv_i && r);
    // Ack window closes after a few cycles
    rxd_o <= rxw_i && (rw == 1);
    if (!rxw_i) rw <= 0;
    else if (rw == 0) rw <= $urandom_range(3, 9);
    else if (rw == 1) rw <= -1;
    else if (rw > 1) rw <= rw - 1;
    // Timer runs on in doze; interrupt at compare, never on the load itself
    if (load_i) tmr <= cmp_i;
    else if (tmr != 0) tmr <= tmr - 1;
    irq_n_o <= !(doze_i && !load_i && tmr == 0);
    if (rst_i) begin
      cw <= 0;
      tw <= 0;
      tmr <= 0;
    end
  end
endmodule // asdc_partner

// [verif/test_asdc_sequencer.sv]
// Self-checking bench for the sequencer
`timescale 1ns/1ns
module test_asdc_sequencer;
  logic        clk_i = 0, rst_i = 1, run_i = 0;
  logic [2:0]  average_exponent_i = 3'h0;
  logic [1:0]  range_sel_cfg_i = 2'h0;
  logic [7:0]  vx = 8'h0, vy = 8'h0, vz = 8'h0;
  wire  [7:0]  conversion_result_i, analog_pin_enable_o, converter_config_o;
  wire  [2:0]  converter_channel_select_o;
  wire  [23:0] tx_data_o;
  wire  [31:0] radio_compare_o;
  wire         conversion_complete_flag_i, tx_ready_i, tx_done_i, rx_done_i, radio_irq_n_i, conv_start_o;
  wire         tx_valid_o, rx_window_o, radio_compare_load_o, radio_doze_o, stopped_o;
  wire         range_select_0_o, range_select_1_o;
  logic [23:0] exp_q[$];
  int          fails = 0, check_count = 0, cyc = 0;
  initial forever #20 clk_i = ~clk_i;
  asdc_sequencer #(.PERIOD_CYC(2000)) uut (
    .clk_i, .rst_i, .average_exponent_i, .range_sel_cfg_i, .run_i, .analog_pin_enable_o,
    .converter_config_o, .converter_channel_select_o, .conv_start_o, .conversion_complete_flag_i,
    .conversion_result_i, .tx_data_o, .tx_valid_o, .tx_ready_i, .tx_done_i, .rx_window_o, .rx_done_i,
    .radio_compare_o, .radio_compare_load_o, .radio_doze_o, .radio_irq_n_i, .stopped_o,
    .range_select_0_o, .range_select_1_o
  );
  asdc_partner far (
    .clk_i, .rst_i, .vx_i(vx), .vy_i(vy), .vz_i(vz), .start_i(conv_start_o),
    .chan_i(converter_channel_select_o), .flag_o(conversion_complete_flag_i),
    .res_o(conversion_result_i), .txv_i(tx_valid_o), .rdy_o(tx_ready_i), .txd_o(tx_done_i),
    .rxw_i(rx_window_o), .rxd_o(rx_done_i), .cmp_i(radio_compare_o), .load_i(radio_compare_load_o),
    .doze_i(radio_doze_o), .irq_n_o(radio_irq_n_i)
  );
  task automatic check(input string what, input logic [23:0] e, input logic [23:0] s);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Result watcher and hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (!rst_i && tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("wrong value tx word expected none seen %h", tx_data_o);
      end else check("tx word", exp_q.pop_front(), tx_data_o);
    end
    if (cyc == 80000) begin
      fails++;
      stop_test();
    end
  end
  // Eighteen loops through every exponent, full-scale x and y and zero z at the largest
  initial begin
    void'($urandom(32'h48ed));
    repeat (2) @(posedge clk_i);
    @(negedge clk_i) rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    check("range at reset", 24'h0, {22'h0, range_select_1_o, range_select_0_o});
    for (int k = 0; k < 18; k++) begin
      average_exponent_i = 3'(k);
      range_sel_cfg_i = 2'($urandom);
      vx = (k == 7) ? 8'hff : 8'($urandom);
      vy = (k == 7) ? 8'hff : 8'($urandom);
      vz = (k == 15) ? 8'h00 : 8'($urandom);
      exp_q.push_back({~vx, ~vy, vz});
      run_i = 1'b1;
      for (int t = 0; t < 20 && conv_start_o !== 1'b1; t++) @(negedge clk_i);
      check("conv start", 24'h1, {23'h0, conv_start_o});
      run_i = 1'b0;
      for (int t = 0; t < 9000 && stopped_o !== 1'b1; t++) @(negedge clk_i);
      check("stop reached", 24'h1, {23'h0, stopped_o});
      check("range", {22'h0, range_sel_cfg_i}, {22'h0, range_select_1_o, range_select_0_o});
      for (int t = 0; t < 3000 && stopped_o !== 1'b0; t++) @(negedge clk_i);
      check("stopped", 24'h0, {23'h0, stopped_o});
      $display("test loop %0d done", k);
    end
    check("words left", 24'h0, 24'(exp_q.size()));
    stop_test();
  end
endmodule // test_asdc_sequencer
